// ### sbi_dev_end.sv
// device end: bus pins, handshake, phase decode and transceiver controls
`timescale 1ns/100ps
module sbi_dev_end
  import sbi_pkg::*;
#(
  parameter int TX_DEPTH = FIFO_DEPTH
) (
  input  wire logic              clk_sys_in,
  input  wire logic              nrst_in,
  sbi_bus_if.dev                 bus,
  input  wire logic              role_target_in,
  input  wire logic              role_initiator_in,
  input  wire logic [2:0]        phase_in,
  input  wire logic              target_go_in,
  input  wire logic              atn_request_in,
  input  wire logic              arbitrate_in,
  input  wire logic              select_in,
  input  wire logic              reset_bus_in,
  input  wire logic              parity_check_enable_in,
  input  wire logic              parity_error_clear_in,
  input  wire logic              tx_valid_in,
  input  wire logic [DATA_W-1:0] tx_data_in,
  output logic                   tx_ready_out,
  output logic                   rx_valid_out,
  output logic      [DATA_W-1:0] rx_data_out,
  output logic                   parity_error_out,
  output sbi_phase_t             phase_out,
  output logic                   phase_reserved_out,
  output logic                   atn_seen_out,
  output logic                   bus_reset_seen_out,
  output logic      [DATA_W-1:0] data_bit_direction_out,
  output logic                   parity_direction_out,
  output logic                   busy_drive_enable_out,
  output logic                   select_drive_enable_out,
  output logic                   bus_reset_drive_enable_out,
  output logic                   target_group_drive_out,
  output logic                   initiator_group_drive_out
);
  // ==========================================================
  // declarations
  logic [BUS_W+CTL_W-1:0] sync1;
  logic [BUS_W+CTL_W-1:0] sync2;
  logic [BUS_W-1:0]       dat_a;
  logic [CTL_W-1:0]       ctl_a;
  sbi_state_t             state;
  sbi_state_t             next_state;
  logic                   tgt;
  logic                   ini;
  logic                   own;
  logic                   next_own;
  logic                   drive;
  logic                   next_drive;
  logic                   sending;
  logic                   next_sending;
  logic [2:0]             tphase;
  logic [2:0]             next_tphase;
  logic [DATA_W-1:0]      tx_byte;
  logic [DATA_W-1:0]      next_tx_byte;
  logic [DATA_W-1:0]      next_rx_data;
  logic                   next_rx_valid;
  logic                   next_perr;
  logic [CTL_W-1:0]       next_ctl;
  logic [BUS_W-1:0]       next_dat;
  logic                   peer;
  logic                   start;
  logic                   capture;
  logic                   fifo_valid;
  logic [DATA_W-1:0]      fifo_data;
  logic                   fifo_pop;
  // ==========================================================
  // transmit buffer; a full buffer stalls the user source
  sbi_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .clk_sys_in    (clk_sys_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (tx_valid_in),
    .in_data_in    (tx_data_in),
    .in_ready_out  (tx_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (fifo_pop)
  );
  // ==========================================================
  // bus lines change with no regard to our clock
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= {bus.ctl_n, bus.dat_n};
      sync2 <= sync1;
    end
  end
  // lines are active low: a low wire is a logical one
  assign dat_a = ~sync2[BUS_W-1:0];
  assign ctl_a = ~sync2[BUS_W+CTL_W-1:BUS_W];
  // ==========================================================
  // handshake
  always_comb begin
    peer          = tgt ? ctl_a[L_ACK] : ctl_a[L_REQ];
    next_state    = state;
    next_own      = own;
    next_drive    = drive;
    next_sending  = sending;
    next_tphase   = tphase;
    next_tx_byte  = tx_byte;
    next_rx_valid = 1'b0;
    next_rx_data  = rx_data_out;
    capture       = 1'b0;
    fifo_pop      = 1'b0;
    start         = (tgt & target_go_in & ~peer) | (ini & peer);
    unique case (state)
      SBI_IDLE: begin
        next_own     = 1'b0;
        next_tphase  = phase_in;
        // direction judged from the initiator's side
        next_sending = tgt ? phase_in[0] : ~ctl_a[L_IO];
        if (start) begin
          if (next_sending) begin
            if (fifo_valid) begin
              fifo_pop     = 1'b1;
              next_tx_byte = fifo_data;
              next_drive   = 1'b1;
              next_state   = SBI_SETUP;
            end
          end else begin
            // data lines are valid while request stands
            capture    = ini;
            next_own   = 1'b1;
            next_state = SBI_HELD;
          end
        end
      end
      SBI_SETUP: begin
        // one cycle of data setup before our strobe
        next_own   = 1'b1;
        next_state = SBI_HELD;
      end
      SBI_HELD: begin
        if (tgt && peer) begin
          capture    = ~sending;
          next_own   = 1'b0;
          next_state = SBI_REL;
        end else if (ini && !peer) begin
          next_own   = 1'b0;
          next_drive = 1'b0;
          next_state = SBI_IDLE;
        end
      end
      SBI_REL: begin
        if (!peer) begin
          next_drive = 1'b0;
          next_state = SBI_IDLE;
        end
      end
    endcase
    if (!tgt && !ini) begin
      next_state = SBI_IDLE;
      next_own   = 1'b0;
      next_drive = 1'b0;
    end
    if (capture) begin
      next_rx_data  = dat_a[DATA_W-1:0];
      next_rx_valid = 1'b1;
    end
    // odd parity over nine lines; the set wins over a clear
    next_perr = (parity_error_out & ~parity_error_clear_in) |
                (capture & parity_check_enable_in & ~(^dat_a));
    next_ctl         = '0;
    next_ctl[L_REQ]  = tgt & next_own;
    next_ctl[L_IO]   = tgt & next_tphase[0];
    next_ctl[L_CD]   = tgt & next_tphase[1];
    next_ctl[L_MSG]  = tgt & next_tphase[2];
    next_ctl[L_ACK]  = ini & next_own;
    next_ctl[L_ATN]  = ini & atn_request_in;
    next_ctl[L_BSY]  = arbitrate_in | tgt;
    next_ctl[L_SEL]  = select_in;
    next_ctl[L_RST]  = reset_bus_in;
    next_dat         = '0;
    if (next_drive) begin
      next_dat = {~(^next_tx_byte), next_tx_byte};
    end
  end
  // ==========================================================
  // registers; reset releases every line and clears the role
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state                      <= SBI_IDLE;
      tgt                        <= 1'b0;
      ini                        <= 1'b0;
      own                        <= 1'b0;
      drive                      <= 1'b0;
      sending                    <= 1'b0;
      tphase                     <= '0;
      tx_byte                    <= '0;
      rx_valid_out               <= 1'b0;
      rx_data_out                <= '0;
      parity_error_out           <= 1'b0;
      phase_out                  <= SBI_DATA_OUT;
      phase_reserved_out         <= 1'b0;
      atn_seen_out               <= 1'b0;
      bus_reset_seen_out         <= 1'b0;
      bus.dev_ctl_oe             <= '0;
      bus.dev_ctl_out            <= '1;
      bus.dev_dat_oe             <= '0;
      bus.dev_dat_out            <= '1;
      data_bit_direction_out     <= '0;
      parity_direction_out       <= 1'b0;
      busy_drive_enable_out      <= 1'b0;
      select_drive_enable_out    <= 1'b0;
      bus_reset_drive_enable_out <= 1'b0;
      target_group_drive_out     <= 1'b0;
      initiator_group_drive_out  <= 1'b0;
    end else begin
      state                      <= next_state;
      // target wins if both roles are requested
      tgt                        <= role_target_in;
      ini                        <= role_initiator_in & ~role_target_in;
      own                        <= next_own;
      drive                      <= next_drive;
      sending                    <= next_sending;
      tphase                     <= next_tphase;
      tx_byte                    <= next_tx_byte;
      rx_valid_out               <= next_rx_valid;
      rx_data_out                <= next_rx_data;
      parity_error_out           <= next_perr;
      phase_out                  <= sbi_phase_t'({ctl_a[L_MSG], ctl_a[L_CD],
                                                  ctl_a[L_IO]});
      phase_reserved_out         <= ctl_a[L_MSG] & ~ctl_a[L_CD];
      atn_seen_out               <= ctl_a[L_ATN];
      bus_reset_seen_out         <= ctl_a[L_RST];
      bus.dev_ctl_oe             <= next_ctl;
      bus.dev_ctl_out            <= ~next_ctl;
      bus.dev_dat_oe             <= next_dat;
      bus.dev_dat_out            <= ~next_dat;
      // direction and enables stay valid even with no transceivers
      data_bit_direction_out     <= {DATA_W{next_drive}};
      parity_direction_out       <= next_drive;
      busy_drive_enable_out      <= next_ctl[L_BSY];
      select_drive_enable_out    <= next_ctl[L_SEL];
      bus_reset_drive_enable_out <= next_ctl[L_RST];
      target_group_drive_out     <= role_target_in;
      initiator_group_drive_out  <= role_initiator_in &
                                    ~role_target_in;
    end
  end
endmodule

// ### sbi_pkg.sv
// shared constants and types for the bus signal interface
package sbi_pkg;
  // ==========================================================
  // widths
  localparam int DATA_W     = 8;
  localparam int BUS_W      = 9;
  localparam int CTL_W      = 9;
  localparam int FIFO_DEPTH = 8;
  // ==========================================================
  // control line positions in the control vectors
  localparam int L_REQ = 0;
  localparam int L_ACK = 1;
  localparam int L_ATN = 2;
  localparam int L_BSY = 3;
  localparam int L_SEL = 4;
  localparam int L_RST = 5;
  localparam int L_IO  = 6;
  localparam int L_CD  = 7;
  localparam int L_MSG = 8;
  // position of the parity bit in the data vectors
  localparam int L_PAR = 8;
  // ==========================================================
  // phase codes {msg, cd, io}, 1 = asserted
  typedef enum logic [2:0] {
    SBI_DATA_OUT = 3'b000,
    SBI_DATA_IN  = 3'b001,
    SBI_COMMAND  = 3'b010,
    SBI_STATUS   = 3'b011,
    SBI_RSVD_A   = 3'b100,
    SBI_RSVD_B   = 3'b101,
    SBI_MSG_OUT  = 3'b110,
    SBI_MSG_IN   = 3'b111
  } sbi_phase_t;
  // ==========================================================
  // handshake states shared by both ends
  typedef enum logic [1:0] {
    SBI_IDLE  = 2'b00,
    SBI_SETUP = 2'b01,
    SBI_HELD  = 2'b10,
    SBI_REL   = 2'b11
  } sbi_state_t;
endpackage

// ### sbi_bus_if.sv
// open-drain bus lines joining the device end and the far end
`timescale 1ns/100ps
interface sbi_bus_if;
  import sbi_pkg::*;
  // ==========================================================
  // wire and drive levels active low (low means asserted); output enables active high
  logic [BUS_W-1:0] dat_n;
  logic [CTL_W-1:0] ctl_n;
  logic [BUS_W-1:0] dev_dat_out;
  logic [BUS_W-1:0] dev_dat_oe;
  logic [CTL_W-1:0] dev_ctl_out;
  logic [CTL_W-1:0] dev_ctl_oe;
  logic [BUS_W-1:0] far_dat_out;
  logic [BUS_W-1:0] far_dat_oe;
  logic [CTL_W-1:0] far_ctl_out;
  logic [CTL_W-1:0] far_ctl_oe;
  // ==========================================================
  // wired-and with termination pulling released lines high
  assign dat_n = ~((dev_dat_oe & ~dev_dat_out) | (far_dat_oe & ~far_dat_out));
  assign ctl_n = ~((dev_ctl_oe & ~dev_ctl_out) | (far_ctl_oe & ~far_ctl_out));
  modport dev (
    input  dat_n,
    input  ctl_n,
    output dev_dat_out,
    output dev_dat_oe,
    output dev_ctl_out,
    output dev_ctl_oe
  );
  modport far (
    input  dat_n,
    input  ctl_n,
    output far_dat_out,
    output far_dat_oe,
    output far_ctl_out,
    output far_ctl_oe
  );
endinterface

// ### sbi_fifo.sv
// transmit byte fifo with valid and ready on both sides
`timescale 1ns/100ps
module sbi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             not_full;
  logic             not_empty;
  logic             push;
  logic             pop;
  // ==========================================================
  // pointer and level logic
  always_comb begin
    push        = in_valid_in & not_full;
    pop         = out_ready_in & not_empty;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + CW'(push) - CW'(pop);
  end
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      not_full  <= 1'b1;
      not_empty <= 1'b0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      not_full  <= (next_count != CW'(DEPTH));
      not_empty <= (next_count != '0);
    end
  end
  // storage needs no reset; only written entries are ever read
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  assign in_ready_out  = not_full;
  assign out_valid_out = not_empty;
  assign out_data_out  = mem[rd_ptr];
endmodule

// ### sbi_far_end.sv
// far end: the other initiator or target on the bus
`timescale 1ns/100ps
module sbi_far_end
  import sbi_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              nrst_in,
  sbi_bus_if.far                 bus,
  input  wire logic              role_target_in,
  input  wire logic [2:0]        phase_in,
  input  wire logic              target_go_in,
  input  wire logic              atn_request_in,
  input  wire logic              select_in,
  input  wire logic              tx_valid_in,
  input  wire logic [DATA_W-1:0] tx_data_in,
  output logic                   tx_taken_out,
  output logic                   rx_valid_out,
  output logic      [DATA_W-1:0] rx_data_out,
  output logic                   atn_seen_out
);
  // ==========================================================
  // declarations
  logic [BUS_W+CTL_W-1:0] sync1;
  logic [BUS_W+CTL_W-1:0] sync2;
  logic [BUS_W-1:0]       dat_a;
  logic [CTL_W-1:0]       ctl_a;
  sbi_state_t             state;
  sbi_state_t             next_state;
  logic                   own;
  logic                   next_own;
  logic                   drive;
  logic                   next_drive;
  logic                   sending;
  logic                   next_sending;
  logic [2:0]             tphase;
  logic [2:0]             next_tphase;
  logic [DATA_W-1:0]      tx_byte;
  logic [DATA_W-1:0]      next_tx_byte;
  logic                   next_taken;
  logic                   capture;
  logic                   peer;
  logic [CTL_W-1:0]       next_ctl;
  logic [BUS_W-1:0]       next_dat;
  // ==========================================================
  // two-flop synchroniser on every bus line
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= {bus.ctl_n, bus.dat_n};
      sync2 <= sync1;
    end
  end
  assign dat_a = ~sync2[BUS_W-1:0];
  assign ctl_a = ~sync2[BUS_W+CTL_W-1:BUS_W];
  // ==========================================================
  // handshake, same shape as the device end
  always_comb begin
    peer         = role_target_in ? ctl_a[L_ACK] : ctl_a[L_REQ];
    next_state   = state;
    next_own     = own;
    next_drive   = drive;
    next_sending = sending;
    next_tphase  = tphase;
    next_tx_byte = tx_byte;
    next_taken   = 1'b0;
    capture      = 1'b0;
    unique case (state)
      SBI_IDLE: begin
        next_own     = 1'b0;
        next_tphase  = phase_in;
        next_sending = role_target_in ? phase_in[0] : ~ctl_a[L_IO];
        if ((role_target_in & target_go_in & ~peer) |
            (~role_target_in & peer)) begin
          if (next_sending) begin
            if (tx_valid_in) begin
              next_taken   = 1'b1;
              next_tx_byte = tx_data_in;
              next_drive   = 1'b1;
              next_state   = SBI_SETUP;
            end
          end else begin
            capture    = ~role_target_in;
            next_own   = 1'b1;
            next_state = SBI_HELD;
          end
        end
      end
      SBI_SETUP: begin
        next_own   = 1'b1;
        next_state = SBI_HELD;
      end
      SBI_HELD: begin
        if (role_target_in && peer) begin
          capture    = ~sending;
          next_own   = 1'b0;
          next_state = SBI_REL;
        end else if (!role_target_in && !peer) begin
          next_own   = 1'b0;
          next_drive = 1'b0;
          next_state = SBI_IDLE;
        end
      end
      SBI_REL: begin
        if (!peer) begin
          next_drive = 1'b0;
          next_state = SBI_IDLE;
        end
      end
    endcase
    next_ctl        = '0;
    next_ctl[L_REQ] = role_target_in & next_own;
    next_ctl[L_IO]  = role_target_in & next_tphase[0];
    next_ctl[L_CD]  = role_target_in & next_tphase[1];
    next_ctl[L_MSG] = role_target_in & next_tphase[2];
    next_ctl[L_ACK] = ~role_target_in & next_own;
    next_ctl[L_ATN] = ~role_target_in & atn_request_in;
    next_ctl[L_BSY] = role_target_in;
    next_ctl[L_SEL] = select_in;
    next_dat        = '0;
    if (next_drive) begin
      next_dat = {~(^next_tx_byte), next_tx_byte};
    end
  end
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state           <= SBI_IDLE;
      own             <= 1'b0;
      drive           <= 1'b0;
      sending         <= 1'b0;
      tphase          <= '0;
      tx_byte         <= '0;
      tx_taken_out    <= 1'b0;
      rx_valid_out    <= 1'b0;
      rx_data_out     <= '0;
      atn_seen_out    <= 1'b0;
      bus.far_ctl_oe  <= '0;
      bus.far_ctl_out <= '1;
      bus.far_dat_oe  <= '0;
      bus.far_dat_out <= '1;
    end else begin
      state           <= next_state;
      own             <= next_own;
      drive           <= next_drive;
      sending         <= next_sending;
      tphase          <= next_tphase;
      tx_byte         <= next_tx_byte;
      tx_taken_out    <= next_taken;
      rx_valid_out    <= capture;
      rx_data_out     <= capture ? dat_a[DATA_W-1:0] : rx_data_out;
      atn_seen_out    <= ctl_a[L_ATN];
      bus.far_ctl_oe  <= next_ctl;
      bus.far_ctl_out <= ~next_ctl;
      bus.far_dat_oe  <= next_dat;
      bus.far_dat_out <= ~next_dat;
    end
  end
endmodule

// ### sbi_props.sv
// bus line assertions between the two ends
`timescale 1ns/100ps
module sbi_props
  import sbi_pkg::*;
(
  input wire logic             clk_sys_in,
  input wire logic             nrst_in,
  input wire logic [BUS_W-1:0] dat_n,
  input wire logic [CTL_W-1:0] ctl_n,
  input wire logic [CTL_W-1:0] dev_ctl_oe,
  input wire logic [CTL_W-1:0] dev_ctl_out,
  input wire logic [CTL_W-1:0] far_ctl_oe
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  // ====
  // wire rules
  rst_release_a: assert property (
    $rose(nrst_in) |-> ((dev_ctl_oe | far_ctl_oe) == '0))
    else $error("line driven after reset");
  drive_low_a: assert property ((dev_ctl_oe & dev_ctl_out) == '0)
    else $error("driven line not low");
  phase_owner_a: assert property (
    !(|dev_ctl_oe[L_MSG:L_IO] && |far_ctl_oe[L_MSG:L_IO]))
    else $error("phase driven by both ends");
  phase_hold_a: assert property (
    !ctl_n[L_REQ] && $past(ctl_n[L_REQ]) == 1'b0 |->
    $stable(ctl_n[L_MSG:L_IO]))
    else $error("phase moved under request");
  ack_answer_a: assert property (
    $fell(ctl_n[L_ACK]) |-> !ctl_n[L_REQ])
    else $error("ack without request");
  req_stands_a: assert property (
    $rose(ctl_n[L_REQ]) |-> !ctl_n[L_ACK])
    else $error("request dropped before ack");
  ack_drop_a: assert property (
    $rose(ctl_n[L_REQ]) |-> ##[2:4] ctl_n[L_ACK])
    else $error("ack not released in time");
  parity_odd_a: assert property (
    !ctl_n[L_REQ] && !ctl_n[L_ACK] |-> ^(~dat_n))
    else $error("bus byte parity not odd");
  reset_owner_a: assert property (
    !ctl_n[L_RST] |-> dev_ctl_oe[L_RST])
    else $error("bus reset from wrong end");
endmodule

// ### test_scsi_bus_signal_interface.sv
// self-checking bench: device end facing the far end
`timescale 1ns/100ps
module test_scsi_bus_signal_interface;
  import sbi_pkg::*;
  logic       clk_sys_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic [2:0] d_ph, f_ph;
  logic [7:0] d_txd, f_txd, d_rxd, f_rxd, dir;
  logic       d_tgt, d_ini, d_go, d_atn, d_arb, d_sel, d_rst, d_pce, d_txv;
  logic       f_tgt, f_go, f_txv, f_tk, f_rxv, f_atns;
  logic       rdy, d_rxv, perr, rsvd, rsts, pdir, bsye, sele, rste, tg, ig;
  logic [8:0] ctl_n;
  sbi_phase_t ph;
  int         num_errors = 0;
  int         n_checks = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  // ====
  // the two ends and the checker
  sbi_bus_if u_sbi_bus_if ();
  assign ctl_n = u_sbi_bus_if.ctl_n;
  sbi_dev_end u_sbi_dev_end (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .bus(u_sbi_bus_if.dev),
    .role_target_in(d_tgt), .role_initiator_in(d_ini), .phase_in(d_ph),
    .target_go_in(d_go), .atn_request_in(d_atn), .arbitrate_in(d_arb),
    .select_in(d_sel), .reset_bus_in(d_rst), .parity_check_enable_in(d_pce),
    .parity_error_clear_in(1'b0), .tx_valid_in(d_txv), .tx_data_in(d_txd),
    .tx_ready_out(rdy), .rx_valid_out(d_rxv), .rx_data_out(d_rxd),
    .parity_error_out(perr), .phase_out(ph), .phase_reserved_out(rsvd),
    .atn_seen_out(), .bus_reset_seen_out(rsts),
    .data_bit_direction_out(dir), .parity_direction_out(pdir),
    .busy_drive_enable_out(bsye), .select_drive_enable_out(sele),
    .bus_reset_drive_enable_out(rste), .target_group_drive_out(tg),
    .initiator_group_drive_out(ig));
  sbi_far_end u_sbi_far_end (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .bus(u_sbi_bus_if.far),
    .role_target_in(f_tgt), .phase_in(f_ph), .target_go_in(f_go),
    .atn_request_in(1'b0), .select_in(1'b0), .tx_valid_in(f_txv),
    .tx_data_in(f_txd), .tx_taken_out(f_tk), .rx_valid_out(f_rxv),
    .rx_data_out(f_rxd), .atn_seen_out(f_atns));
  sbi_props u_sbi_props (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .dat_n(u_sbi_bus_if.dat_n),
    .ctl_n(u_sbi_bus_if.ctl_n), .dev_ctl_oe(u_sbi_bus_if.dev_ctl_oe),
    .dev_ctl_out(u_sbi_bus_if.dev_ctl_out),
    .far_ctl_oe(u_sbi_bus_if.far_ctl_oe));
  // ====
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // pulses are one cycle wide, so poll every edge under a bound
  task automatic wt(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (s !== 1'b1 && n < 200);
    chk(s, 1'b1);
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_ctrl;
    {d_tgt, d_arb, d_sel, d_rst} <= 4'hf;
    // one edge to register, two to synchronise, one to report
    repeat (5) @(posedge clk_sys_in);
    chk({bsye, sele, rste, tg, ig}, 5'h1e);
    chk({rsts, ctl_n[L_RST], ctl_n[L_SEL], ctl_n[L_BSY]}, 4'h8);
    {d_tgt, d_ini, d_rst} <= 3'h2;
    repeat (4) @(posedge clk_sys_in);
    chk({rste, tg, ig, ctl_n[L_RST]}, 4'h3);
    {d_arb, d_sel} <= 2'h0;
    $display("t_ctrl done");
  endtask
  task automatic t_far_send;
    logic [11:0] e;
    {f_tgt, d_atn} <= 2'h3;
    repeat (6) @(posedge clk_sys_in);
    chk({f_atns, ctl_n[L_ATN]}, 2'h2);
    d_atn <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      // odd codes move data toward the initiator: the far end sends
      e = {i[2:1] == 2'b10, i[2:0], 8'h3c ^ i[7:0]};
      f_ph  <= i[2:0];
      f_txd <= 8'h3c ^ i[7:0];
      d_txd <= 8'h3c ^ i[7:0];
      f_txv <= i[0];
      d_txv <= ~i[0];
      f_go  <= 1'b1;
      @(posedge clk_sys_in);
      d_txv <= 1'b0;
      if (i[0]) begin
        wt(f_tk);
        f_txv <= 1'b0;
        wt(d_rxv);
        chk({rsvd, ph, d_rxd}, e);
      end else begin
        wt(f_rxv);
        chk({rsvd, ph, f_rxd}, e);
      end
      chk({dir, pdir, perr}, {{9{~i[0]}}, 1'b0});
      // stop the far target before it asks for a second byte
      f_go <= 1'b0;
      repeat (12) @(posedge clk_sys_in);
    end
    repeat (20) @(posedge clk_sys_in);
    $display("t_far_send done");
  endtask
  // a ninth byte is offered while the device target is held with d_go low and must be refused
  task automatic t_dev_send;
    {f_tgt, f_go, d_ini, d_tgt} <= 4'h1;
    d_ph <= 3'h1;
    for (int i = 0; i < 9; i++) begin
      d_txv <= 1'b1;
      d_txd <= 8'h81 + i[7:0];
      @(posedge clk_sys_in);
    end
    d_txv <= 1'b0;
    @(posedge clk_sys_in);
    chk(rdy, 1'b0);
    d_go <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wt(f_rxv);
      chk({dir, pdir, f_rxd}, {9'h1ff, 8'h81 + i[7:0]});
    end
    d_go <= 1'b0;
    repeat (20) @(posedge clk_sys_in);
    chk({rdy, dir, pdir}, 10'h200);
    $display("t_dev_send done");
  endtask
  // ====
  // main sequence and watchdog
  initial begin
    {d_tgt, d_ini, d_go, d_atn, d_arb, d_sel, d_rst, d_txv} = 8'h0;
    {f_tgt, f_go, f_txv, d_ph, f_ph, d_txd, f_txd} = 25'h0;
    d_pce = 1'b1;
    repeat (16) @(posedge clk_sys_in);
    chk({bsye, sele, rste, tg, ig, pdir, dir}, 14'h0);
    chk(ctl_n, 9'h1ff);
    nrst_in <= 1'b1;
    t_ctrl;
    t_far_send;
    t_dev_send;
    final_report;
  end
  // all scenarios need well under a thousand cycles
  initial begin
    repeat (8000) @(posedge clk_sys_in);
    num_errors++;
    final_report;
  end
endmodule
